// ### lasr_top.v
// Function
// RL1: Driver alarm after 128 idle transmit periods
// RL2: Driver alarm clears when pulses resume
// RL3: Receive loss bit follows receiver loss
// RL4: Lock loss set beyond 0.5% deviation
// RL5: Lock loss clears when back in tolerance
// RL6: Analog loss bit follows amplitude detector
// RL7: Digital loss after mode-dependent pulse-free run
// RL8: Digital loss counts pulse absence only
// RL9: E3 applies run inside analog detector
// RL10: Pattern loss while detector enabled, unsynced
// RL11: Pattern loss clears on detector sync
// RL12: Bits three and seven reserved, zero
// RL13: Self-monitor select picks driver source
// RL14: Disable bit stops digital loss detector
// RL15: Change flag pulses on receive loss edges
// RL16: Status reads have no side effects
// RL17: Receive loss from enabled analog/digital
`timescale 1ns/100ps
`default_nettype none
`include "lasr_defines.vh"

module lasr_top (
  input  wire                      CLK,
  input  wire                      RST_B,
  input  wire [`LASR_ADDR_W-1:0]   ADDR,
  input  wire                      CS_B,
  input  wire                      RD_B,
  input  wire                      WR_B,
  input  wire [`LASR_DATA_W-1:0]   DATA_IN,
  output reg  [`LASR_DATA_W-1:0]   DATA_OUT,
  output reg                       DATA_OE_B,
  input  wire [`LASR_NUM_CH-1:0]   TRANSMIT_CLOCK_IN,
  input  wire [`LASR_NUM_CH-1:0]   TX_LINE_POSITIVE,
  input  wire [`LASR_NUM_CH-1:0]   TX_LINE_NEGATIVE,
  input  wire [`LASR_NUM_CH-1:0]   MONITOR_INPUT_POSITIVE,
  input  wire [`LASR_NUM_CH-1:0]   MONITOR_INPUT_NEGATIVE,
  input  wire [`LASR_NUM_CH-1:0]   TX_SELF_MONITOR_SELECT,
  input  wire [`LASR_NUM_CH-1:0]   RX_BIT_TICK,
  input  wire [`LASR_NUM_CH-1:0]   RX_PULSE,
  input  wire [`LASR_NUM_CH-1:0]   MODE_E3,
  input  wire [`LASR_NUM_CH-1:0]   ANALOG_AMPLITUDE_LOW,
  input  wire [`LASR_NUM_CH-1:0]   ANALOG_LOSS_DETECTOR_DISABLE,
  input  wire [`LASR_NUM_CH-1:0]   DIGITAL_LOSS_DETECTOR_DISABLE,
  input  wire [`LASR_NUM_CH-1:0]   REF_CLOCK_TICK,
  input  wire [`LASR_NUM_CH-1:0]   RECOVERED_CLOCK_TICK,
  input  wire [`LASR_NUM_CH-1:0]   PRBS_DETECT_ENABLE,
  input  wire [`LASR_NUM_CH-1:0]   PRBS_IN_SYNC,
  output reg  [`LASR_NUM_CH-1:0]   RECEIVE_LOSS_CHANGE_FLAG
);

  // ----------------------------------------------------------------------
  // Per-channel status collection
  // ----------------------------------------------------------------------
  wire [`LASR_NUM_CH*8-1:0] status_all;
  wire [`LASR_NUM_CH-1:0]   rx_loss_change;

  genvar g;
  generate
    for (g = 0; g < `LASR_NUM_CH; g = g + 1) begin : g_ch
      reg        prev_pos_r;
      reg        prev_neg_r;
      reg  [7:0] idle_cnt_r;
      reg        driver_monitor_alarm_r;
      reg  [7:0] run_cnt_r;
      reg        run_hit_r;
      reg        analog_signal_loss_r;
      reg        digital_signal_loss_r;
      reg        receive_signal_loss_r;
      reg        pattern_sync_loss_r;
      wire       receive_lock_loss;
      wire       mon_pos;
      wire       mon_neg;
      wire       mon_edge;
      wire [7:0] run_limit;
      wire       rx_loss_nxt;

      // --------------------------------------------------------------
      // Driver monitor
      // --------------------------------------------------------------
      assign mon_pos  = TX_SELF_MONITOR_SELECT[g] ? TX_LINE_POSITIVE[g]
                                                  : MONITOR_INPUT_POSITIVE[g]; // see RL13
      assign mon_neg  = TX_SELF_MONITOR_SELECT[g] ? TX_LINE_NEGATIVE[g]
                                                  : MONITOR_INPUT_NEGATIVE[g]; // see RL13
      assign mon_edge = (mon_pos != prev_pos_r) || (mon_neg != prev_neg_r);

      always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          prev_pos_r             <= 1'b0;
          prev_neg_r             <= 1'b0;
          idle_cnt_r             <= 8'h00;
          driver_monitor_alarm_r <= 1'b0;
        end else begin
          prev_pos_r <= mon_pos;
          prev_neg_r <= mon_neg;
          if (mon_edge) begin
            idle_cnt_r             <= 8'h00;
            driver_monitor_alarm_r <= 1'b0; // see RL2
          end else if (TRANSMIT_CLOCK_IN[g]) begin
            if (idle_cnt_r != `LASR_DRV_IDLE_PERIODS) begin
              idle_cnt_r <= idle_cnt_r + 8'h01;
            end
            // Alarm on the 128th idle period
            if (idle_cnt_r == (`LASR_DRV_IDLE_PERIODS - 8'h01)) begin
              driver_monitor_alarm_r <= 1'b1; // see RL1
            end
          end
        end
      end

      // --------------------------------------------------------------
      // Pulse-absence run and loss detectors
      // --------------------------------------------------------------
      // The run counter sees only pulse presence, never amplitude.
      assign run_limit = MODE_E3[g] ? `LASR_DIG_RUN_E3_BITS : `LASR_DIG_RUN_DS3_BITS;

      always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          run_cnt_r <= 8'h00;
          run_hit_r <= 1'b0;
        end else if (RX_PULSE[g]) begin
          run_cnt_r <= 8'h00; // see RL8
          run_hit_r <= 1'b0;
        end else if (RX_BIT_TICK[g] && !run_hit_r) begin
          run_cnt_r <= run_cnt_r + 8'h01;
          if (run_cnt_r == (run_limit - 8'h01)) begin
            run_hit_r <= 1'b1; // see RL7
          end
        end
      end

      always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          analog_signal_loss_r  <= 1'b0;
          digital_signal_loss_r <= 1'b0;
        end else begin
          // E3 qualifies amplitude loss with the absence run;
          // DS3/STS-1 report amplitude alone as a line-quality aid.
          if (ANALOG_LOSS_DETECTOR_DISABLE[g]) begin
            analog_signal_loss_r <= 1'b0;
          end else if (MODE_E3[g]) begin
            analog_signal_loss_r <= ANALOG_AMPLITUDE_LOW[g] && run_hit_r; // see RL9
          end else begin
            analog_signal_loss_r <= ANALOG_AMPLITUDE_LOW[g]; // see RL6 see RL9
          end
          digital_signal_loss_r <= run_hit_r && !DIGITAL_LOSS_DETECTOR_DISABLE[g]; // see RL14
        end
      end

      // --------------------------------------------------------------
      // Receive loss and its change flag
      // --------------------------------------------------------------
      assign rx_loss_nxt = analog_signal_loss_r || digital_signal_loss_r; // see RL17

      always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          receive_signal_loss_r <= 1'b0;
        end else begin
          receive_signal_loss_r <= rx_loss_nxt; // see RL3
        end
      end

      assign rx_loss_change[g] = rx_loss_nxt != receive_signal_loss_r; // see RL15

      // --------------------------------------------------------------
      // Pattern sync loss
      // --------------------------------------------------------------
      always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          pattern_sync_loss_r <= 1'b0;
        end else begin
          pattern_sync_loss_r <= PRBS_DETECT_ENABLE[g] && !PRBS_IN_SYNC[g]; // see RL10 see RL11
        end
      end

      // --------------------------------------------------------------
      // Recovered clock lock check
      // --------------------------------------------------------------
      lasr_lock u_lock (
        .CLK         (CLK),
        .RST_B       (RST_B),
        .ref_tick    (REF_CLOCK_TICK[g]),
        .rcv_tick    (RECOVERED_CLOCK_TICK[g]),
        .lock_loss_r (receive_lock_loss)
      );

      // Reserved bits are tied low
      assign status_all[g*8 +: 8] = {1'b0,                    // see RL12
                                     pattern_sync_loss_r,
                                     digital_signal_loss_r,
                                     analog_signal_loss_r,
                                     1'b0,                    // see RL12
                                     receive_lock_loss,
                                     receive_signal_loss_r,
                                     driver_monitor_alarm_r};
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Change flag outputs
  // ----------------------------------------------------------------------
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RECEIVE_LOSS_CHANGE_FLAG <= {`LASR_NUM_CH{1'b0}};
    end else begin
      RECEIVE_LOSS_CHANGE_FLAG <= rx_loss_change; // see RL15
    end
  end

  // ----------------------------------------------------------------------
  // Parallel register port
  // ----------------------------------------------------------------------
  // Only alarm_status_ch0..ch5 live here; other addresses read as zero.
  // Reads are pure views of live levels, so back-to-back polling is safe.
  wire [2:0] ch_sel;
  wire       rd_req;
  wire       hit;
  wire [7:0] rd_data;

  assign ch_sel  = ADDR[6:4];
  assign rd_req  = !CS_B && !RD_B && WR_B;
  assign hit     = (ADDR[3:0] == `LASR_STATUS_OFS) && (ch_sel < 3'h6);
  assign rd_data = hit ? status_all[ch_sel*8 +: 8] : `LASR_UNMAPPED_DATA; // see RL16

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DATA_OUT  <= `LASR_STATUS_RST;
      DATA_OE_B <= 1'b1;
    end else begin
      // Writes never reach a status register and are dropped here
      if (rd_req) begin
        DATA_OUT  <= rd_data; // see RL16
        DATA_OE_B <= 1'b0;
      end else begin
        DATA_OUT  <= `LASR_STATUS_RST;
        DATA_OE_B <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### lasr_defines.vh
`ifndef LASR_DEFINES_VH
`define LASR_DEFINES_VH

// ----------------------------------------------------------------------
// Channel map and parallel register port
// ----------------------------------------------------------------------
`define LASR_NUM_CH         6
`define LASR_ADDR_W         7
`define LASR_DATA_W         8
// Low address nibble of the per-channel alarm status register
`define LASR_STATUS_OFS     4'h3
// Byte addresses of alarm_status_ch0 .. alarm_status_ch5
`define LASR_ALARM_STATUS_CH0 7'h03
`define LASR_ALARM_STATUS_CH1 7'h13
`define LASR_ALARM_STATUS_CH2 7'h23
`define LASR_ALARM_STATUS_CH3 7'h33
`define LASR_ALARM_STATUS_CH4 7'h43
`define LASR_ALARM_STATUS_CH5 7'h53
`define LASR_STATUS_RST     8'h00
`define LASR_UNMAPPED_DATA  8'h00

// ----------------------------------------------------------------------
// Alarm status bit positions
// ----------------------------------------------------------------------
`define LASR_BIT_DRV_MON    0
`define LASR_BIT_RX_LOS     1
`define LASR_BIT_RX_LOL     2
`define LASR_BIT_RSVD3      3
`define LASR_BIT_ANA_LOSS   4
`define LASR_BIT_DIG_LOSS   5
`define LASR_BIT_PRBS_LS    6
`define LASR_BIT_RSVD7      7

// ----------------------------------------------------------------------
// Detector counts
// ----------------------------------------------------------------------
// Driver monitor: 128 transmit clock periods, tolerance +/- 32
`define LASR_DRV_IDLE_PERIODS 8'h80
// Digital loss runs, in bit times (E3 window 10..255, DS3/STS-1 100..250)
`define LASR_DIG_RUN_E3_BITS  8'h20
`define LASR_DIG_RUN_DS3_BITS 8'haf
// Lock window in reference ticks; 0.5 % of 1024 is 5.12 ticks
`define LASR_LOCK_WIN       12'h400
`define LASR_LOCK_TOL       12'h005

`endif

// ### lasr_lock.v
`timescale 1ns/100ps
`default_nettype none
`include "lasr_defines.vh"

module lasr_lock (
  input  wire CLK,
  input  wire RST_B,
  input  wire ref_tick,
  input  wire rcv_tick,
  output reg  lock_loss_r
);

  reg  [11:0] win_cnt_r;
  reg  [11:0] rcv_cnt_r;
  wire        win_end;
  wire [11:0] rcv_total;
  wire        too_fast;
  wire        too_slow;

  // ----------------------------------------------------------------------
  // Frequency comparison over a fixed reference window
  // ----------------------------------------------------------------------
  // Window end counted as the last reference tick; the recovered tick of
  // that same cycle still counts toward the total.
  assign win_end   = ref_tick && (win_cnt_r == (`LASR_LOCK_WIN - 12'h001));
  assign rcv_total = rcv_cnt_r + {11'h000, rcv_tick};
  assign too_fast  = rcv_total > (`LASR_LOCK_WIN + `LASR_LOCK_TOL);
  assign too_slow  = rcv_total < (`LASR_LOCK_WIN - `LASR_LOCK_TOL);

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      win_cnt_r   <= 12'h000;
      rcv_cnt_r   <= 12'h000;
      lock_loss_r <= 1'b0;
    end else begin
      if (win_end) begin
        win_cnt_r   <= 12'h000;
        rcv_cnt_r   <= 12'h000;
        lock_loss_r <= too_fast || too_slow; // see RL4 see RL5
      end else begin
        if (ref_tick) begin
          win_cnt_r <= win_cnt_r + 12'h001;
        end
        // Saturate so a runaway recovered clock cannot wrap into lock
        if (rcv_tick && (rcv_cnt_r != 12'hfff)) begin
          rcv_cnt_r <= rcv_cnt_r + 12'h001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### lasr_alarm_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "lasr_defines.vh"
// ----------------------------------------
// Register port and status checks
// ----------------------------------------
module lasr_alarm_properties (
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic [6:0] ADDR,
  input wire logic       CS_B,
  input wire logic       RD_B,
  input wire logic       WR_B,
  input wire logic [7:0] DATA_OUT,
  input wire logic       DATA_OE_B,
  input wire logic [5:0] ANALOG_LOSS_DETECTOR_DISABLE,
  input wire logic [5:0] DIGITAL_LOSS_DETECTOR_DISABLE,
  input wire logic [5:0] PRBS_DETECT_ENABLE,
  input wire logic [5:0] PRBS_IN_SYNC,
  input wire logic [5:0] RECEIVE_LOSS_CHANGE_FLAG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire logic rd = !CS_B && !RD_B && WR_B;
  a_read_drives_bus: assert property (rd |=> !DATA_OE_B)
    else $error("read not answered");
  a_idle_bus_quiet: assert property (!rd |=> DATA_OE_B && DATA_OUT == 8'h00)
    else $error("bus driven outside a read");
  a_unmapped_zero: assert property (
    rd && (ADDR[3:0] != 4'h3 || ADDR > 7'h53) |=> DATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (!DATA_OE_B |-> !DATA_OUT[3] && !DATA_OUT[7])
    else $error("reserved bit set");
  a_flag_one_cycle: assert property (
    $rose(RECEIVE_LOSS_CHANGE_FLAG[1]) |=> !RECEIVE_LOSS_CHANGE_FLAG[1])
    else $error("change flag longer than one cycle");
  a_pattern_loss_level: assert property (
    ($stable(PRBS_DETECT_ENABLE[2]) && $stable(PRBS_IN_SYNC[2]))[*3]
    ##0 (rd && ADDR == `LASR_ALARM_STATUS_CH2)
    |=> DATA_OUT[6] == ($past(PRBS_DETECT_ENABLE[2]) && !$past(PRBS_IN_SYNC[2])))
    else $error("pattern loss bit wrong");
  a_digital_disabled: assert property (
    DIGITAL_LOSS_DETECTOR_DISABLE[3][*3] ##0 (rd && ADDR == `LASR_ALARM_STATUS_CH3)
    |=> !DATA_OUT[5]) else $error("digital loss while disabled");
  a_analog_disabled: assert property (
    ANALOG_LOSS_DETECTOR_DISABLE[1][*3] ##0 (rd && ADDR == `LASR_ALARM_STATUS_CH1)
    |=> !DATA_OUT[4]) else $error("analog loss while disabled");
  c_read: cover property (rd ##1 !DATA_OE_B);
  c_flag: cover property ($rose(RECEIVE_LOSS_CHANGE_FLAG[1]));
  c_pattern: cover property ((rd && ADDR == `LASR_ALARM_STATUS_CH2) ##1 DATA_OUT[6]);
endmodule
bind lasr_top lasr_alarm_properties u_chk (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
  .CS_B(CS_B), .RD_B(RD_B), .WR_B(WR_B), .DATA_OUT(DATA_OUT), .DATA_OE_B(DATA_OE_B),
  .ANALOG_LOSS_DETECTOR_DISABLE(ANALOG_LOSS_DETECTOR_DISABLE),
  .DIGITAL_LOSS_DETECTOR_DISABLE(DIGITAL_LOSS_DETECTOR_DISABLE),
  .PRBS_DETECT_ENABLE(PRBS_DETECT_ENABLE), .PRBS_IN_SYNC(PRBS_IN_SYNC),
  .RECEIVE_LOSS_CHANGE_FLAG(RECEIVE_LOSS_CHANGE_FLAG));
`default_nettype wire

// ### lasr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host processor on the register port
// ----------------------------------------
module lasr_host_model (
  input  wire logic       CLK,
  input  wire logic [7:0] DATA_OUT,
  output var  logic [6:0] ADDR,
  output var  logic       CS_B,
  output var  logic       RD_B,
  output var  logic       WR_B,
  output var  logic [7:0] DATA_IN
);
  initial begin
    ADDR = 7'h00;
    DATA_IN = 8'h00;
    {CS_B, RD_B, WR_B} = 3'h7;
  end
  // Strobes stay low after a read so reads can run back to back
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    {CS_B, RD_B, WR_B} <= 3'h1;
    @(posedge CLK);
    #1 d = DATA_OUT;
  endtask
  // Released lines flip so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    DATA_IN <= d;
    {CS_B, RD_B, WR_B} <= 3'h2;
    @(posedge CLK);
    {CS_B, RD_B, WR_B} <= 3'h7;
    ADDR <= ~a;
    DATA_IN <= ~d;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lasr_defines.vh"
`define CHK(nm, e, g) begin checks_done++; \
  if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
// ----------------------------------------
// Alarm status bench
// ----------------------------------------
module tb_top;
  logic CLK = 1'b0, RST_B = 1'b0, rec_fast = 1'b0;
  wire logic [6:0] ADDR;
  wire logic [7:0] DATA_IN, DATA_OUT;
  wire logic CS_B, RD_B, WR_B, DATA_OE_B;
  wire logic [5:0] chg;
  logic [5:0] tck = 0, txp = 0, txn = 0, mp = 0, mn = 0, btk = 0, rp = 0, rt = 0, ct = 0;
  logic [5:0] self = 6'h3f, e3 = 0, amp = 0, ad = 0, dd = 0, pen = 0, psy = 0;
  logic [5:0] p_en = 6'h3f, tx_tog = 6'h3f, m_tog = 6'h3f;
  logic [15:0] cyc = 16'h0000;
  logic [7:0] rdata;
  int err_total = 0, checks_done = 0, flag_cnt = 0;
  lasr_top DUT (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .CS_B(CS_B), .RD_B(RD_B),
    .WR_B(WR_B), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_B(DATA_OE_B),
    .TRANSMIT_CLOCK_IN(tck), .TX_LINE_POSITIVE(txp), .TX_LINE_NEGATIVE(txn),
    .MONITOR_INPUT_POSITIVE(mp), .MONITOR_INPUT_NEGATIVE(mn), .TX_SELF_MONITOR_SELECT(self),
    .RX_BIT_TICK(btk), .RX_PULSE(rp), .MODE_E3(e3), .ANALOG_AMPLITUDE_LOW(amp),
    .ANALOG_LOSS_DETECTOR_DISABLE(ad), .DIGITAL_LOSS_DETECTOR_DISABLE(dd),
    .REF_CLOCK_TICK(rt), .RECOVERED_CLOCK_TICK(ct), .PRBS_DETECT_ENABLE(pen),
    .PRBS_IN_SYNC(psy), .RECEIVE_LOSS_CHANGE_FLAG(chg));
  lasr_host_model host (.CLK(CLK), .DATA_OUT(DATA_OUT), .ADDR(ADDR), .CS_B(CS_B),
    .RD_B(RD_B), .WR_B(WR_B), .DATA_IN(DATA_IN));
  initial forever #2.5 CLK = ~CLK;
  // Line clocks run at half rate, reference at quarter rate
  always @(posedge CLK) begin
    cyc <= cyc + 16'h0001;
    tck <= {6{cyc[0]}};
    btk <= {6{cyc[0]}};
    rp <= p_en & {6{cyc[0]}};
    rt <= {6{cyc[1:0] == 2'h0}};
    ct <= {6{rec_fast ? cyc[0] : (cyc[1:0] == 2'h0)}};
    txp <= txp ^ (tx_tog & {6{cyc[0]}});
    mn <= mn ^ (m_tog & {6{cyc[0]}});
    if (cyc == 16'h9c40) begin
      err_total++;
      print_verdict;
    end
  end
  always @(negedge CLK) if (chg[1] === 1'b1) flag_cnt++;
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    host.rd(a, rdata);
    `CHK("status", e, rdata & m)
    `CHK("read enable", 1'b0, DATA_OE_B)
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    wt(2);
    RST_B <= 1'b1;
    for (int c = 0; c < 6; c++) rd_chk(7'(16 * c + 3), 8'hff, 8'h00);
    rd_chk(7'h04, 8'hff, 8'h00);
    rd_chk(7'h63, 8'hff, 8'h00);
    host.wr(`LASR_ALARM_STATUS_CH2, 8'hff);
    rd_chk(`LASR_ALARM_STATUS_CH2, 8'hff, 8'h00);
    @(posedge CLK) pen[2] <= 1'b1;
    wt(3);
    rd_chk(`LASR_ALARM_STATUS_CH2, 8'h40, 8'h40);
    @(posedge CLK) psy[2] <= 1'b1;
    wt(3);
    rd_chk(`LASR_ALARM_STATUS_CH2, 8'h40, 8'h00);
    @(posedge CLK) amp[1] <= 1'b1;
    wt(4);
    rd_chk(`LASR_ALARM_STATUS_CH1, 8'h32, 8'h12);
    `CHK("change flags", 1, flag_cnt)
    @(posedge CLK) ad[1] <= 1'b1;
    wt(4);
    rd_chk(`LASR_ALARM_STATUS_CH1, 8'h12, 8'h00);
    `CHK("change flags", 2, flag_cnt)
    // Just short of the shortest allowed run, then beyond the longest
    @(posedge CLK) p_en[3] <= 1'b0;
    wt(196);
    rd_chk(`LASR_ALARM_STATUS_CH3, 8'h32, 8'h00);
    wt(310);
    rd_chk(`LASR_ALARM_STATUS_CH3, 8'h32, 8'h22);
    @(posedge CLK) dd[3] <= 1'b1;
    wt(4);
    rd_chk(`LASR_ALARM_STATUS_CH3, 8'h32, 8'h00);
    @(posedge CLK) {e3[4], amp[4]} <= 2'h3;
    wt(20);
    rd_chk(`LASR_ALARM_STATUS_CH4, 8'h10, 8'h00);
    @(posedge CLK) p_en[4] <= 1'b0;
    wt(530);
    rd_chk(`LASR_ALARM_STATUS_CH4, 8'hff, 8'h32);
    @(posedge CLK) tx_tog[0] <= 1'b0;
    wt(186);
    rd_chk(`LASR_ALARM_STATUS_CH0, 8'h01, 8'h00);
    wt(130);
    rd_chk(`LASR_ALARM_STATUS_CH0, 8'h01, 8'h01);
    @(posedge CLK) tx_tog[0] <= 1'b1;
    wt(4);
    rd_chk(`LASR_ALARM_STATUS_CH0, 8'h01, 8'h00);
    @(posedge CLK) {self[0], tx_tog[0]} <= 2'h0;
    wt(330);
    rd_chk(`LASR_ALARM_STATUS_CH0, 8'h01, 8'h00);
    @(posedge CLK) m_tog[0] <= 1'b0;
    wt(330);
    rd_chk(`LASR_ALARM_STATUS_CH0, 8'h01, 8'h01);
    wt(8200);
    rd_chk(`LASR_ALARM_STATUS_CH5, 8'h04, 8'h00);
    @(posedge CLK) rec_fast <= 1'b1;
    wt(8200);
    rd_chk(`LASR_ALARM_STATUS_CH5, 8'h04, 8'h04);
    @(posedge CLK) rec_fast <= 1'b0;
    wt(8200);
    rd_chk(`LASR_ALARM_STATUS_CH5, 8'h04, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
